// ==== src/tmu_regs.svh ====
// Register indices, field positions, reset values and timing counts of the timer unit
`ifndef TMU_REGS_SVH
`define TMU_REGS_SVH
// Word indices; byte address is index times four
`define TMU_IX_MAIN 8'h00
`define TMU_IX_RDREQ 8'h02
`define TMU_IX_BCLR 8'h04
`define TMU_IX_BSET 8'h05
`define TMU_IX_CAPC 8'h06
`define TMU_IX_DBG 8'h08
`define TMU_IX_EVC 8'h0a
`define TMU_IX_IECLR 8'h0c
`define TMU_IX_IESET 8'h0d
`define TMU_IX_FLAGS 8'h0e
`define TMU_IX_STAT 8'h0f
`define TMU_IX_CNT 8'h10
`define TMU_IX_CNTH 8'h11
`define TMU_IX_PERIOD 8'h14
`define TMU_IX_CMP0 8'h18
`define TMU_IX_CMP0H 8'h19
`define TMU_IX_CMP1 8'h1a
`define TMU_IX_CMP1H 8'h1b
// Field positions
`define TMU_B_SOFT_RESET_BIT 0
`define TMU_B_EN 1
`define TMU_B_MODE 2
`define TMU_B_RUNSB 11
`define TMU_B_RCONT 14
`define TMU_B_RREQ 15
`define TMU_B_DIR 0
`define TMU_B_SINGLE_SHOT_BIT 2
`define TMU_B_CMD 6
`define TMU_B_EVACT 0
`define TMU_B_EVINV 4
`define TMU_B_EVIN_EN 5
`define TMU_B_OVFEO 8
`define TMU_B_MCEO0 12
`define TMU_B_MCEO1 13
`define TMU_F_OVF 0
`define TMU_F_SRDY 3
`define TMU_F_MC0 4
`define TMU_F_MC1 5
`define TMU_S_STOP 3
`define TMU_S_BUSY 7
// Codes and reset values
`define TMU_MODE_8 2'h1
`define TMU_CMD_RETRIG 2'h1
`define TMU_CMD_STOP 2'h2
`define TMU_EVACT_RETRIG 3'h1
`define TMU_EVACT_COUNT 3'h2
`define TMU_RESP_OK 2'h0
`define TMU_RESP_ERR 2'h2
`define TMU_RST_VAL 16'h0000
`define TMU_SYNC_CYC 3
`endif

// ==== src/tmu_pkg.sv ====
// Types of the timer unit
package tmu_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_wsync = 3'b010,
    st_rsync = 3'b100
  } tmu_sync_t;

  typedef struct packed {
    logic [15:0] main;
    logic [15:0] rdreq;
    logic [7:0] ctlb;
    logic [7:0] capc;
    logic [7:0] dbg;
    logic [15:0] evc;
    logic [7:0] ien;
    logic [7:0] flags;
    logic [15:0] cnt;
    logic [7:0] period;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] cnt_rd;
    logic stop;
    logic ev_d;
  } tmu_regs_t;

  typedef struct packed {
    tmu_regs_t r;
    tmu_sync_t sync;
    logic [3:0] sync_cnt;
    logic [7:0] pend_ix;
    logic [7:0] pend_d;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_ix;
    logic [15:0] w_d;
    logic [1:0] w_be;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ar_ix;
    logic irq;
    logic ev_ovf;
    logic ev_mc0;
    logic ev_mc1;
  } tmu_state_t;
endpackage : tmu_pkg

// ==== src/tmu_timer.sv ====
// Timer unit: AXI4-Lite register file, sync model, counter, events and interrupt
// Summary of operation
// - Clock counting halts in standby unless keep_running_asleep is set.
// - Enabled interrupt request raises irq, usable as wake-up from any sleep.
// - Event input actions and event outputs keep working while asleep.
// - soft_reset_bit and enable writes take effect only after sync delay.
// - Control B, capture, count, period, compare writes pass the sync delay.
// - Reads of synchronized registers return values synchronized from counter side.
// - 8-bit width: count 0x10, period 0x14, channel0 0x18, channel1 0x19.
// - 16-bit width: count 0x10-0x11, channels 0x18-0x19, 0x1A-0x1B, no period.
// - single_shot_bit set via control_b_set, cleared via control_b_clear.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tmu_regs.svh"
module tmu_timer import tmu_pkg::*; #(
  parameter int unsigned SYNC_CYC = `TMU_SYNC_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System
  input wire logic standby,
  input wire logic ev_in,
  output logic irq,
  output logic ev_ovf,
  output logic ev_mc0,
  output logic ev_mc1
);
  if (SYNC_CYC < 1 || SYNC_CYC > 15) begin : g_chk
    $error("SYNC_CYC must be 1 to 15");
  end

  tmu_state_t s_ff;
  tmu_state_t nxt_s;

  function automatic logic mapped(input logic [7:0] ix, input logic m8);
    case (ix)
      `TMU_IX_MAIN, `TMU_IX_RDREQ, `TMU_IX_BCLR, `TMU_IX_BSET, `TMU_IX_CAPC,
      `TMU_IX_DBG, `TMU_IX_EVC, `TMU_IX_IECLR, `TMU_IX_IESET, `TMU_IX_FLAGS,
      `TMU_IX_STAT, `TMU_IX_CNT, `TMU_IX_CMP0, `TMU_IX_CMP0H: mapped = 1'b1;
      `TMU_IX_CNTH, `TMU_IX_CMP1, `TMU_IX_CMP1H: mapped = !m8;
      `TMU_IX_PERIOD: mapped = m8;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic logic is_sync(input logic [7:0] ix);
    case (ix)
      `TMU_IX_MAIN, `TMU_IX_BCLR, `TMU_IX_BSET, `TMU_IX_CAPC, `TMU_IX_CNT,
      `TMU_IX_CNTH, `TMU_IX_PERIOD, `TMU_IX_CMP0, `TMU_IX_CMP0H,
      `TMU_IX_CMP1, `TMU_IX_CMP1H: is_sync = 1'b1;
      default: is_sync = 1'b0;
    endcase
  endfunction : is_sync

  function automatic logic [15:0] rd_val(input tmu_regs_t r, input logic [7:0] ix,
                                         input logic m8, input logic busy);
    case (ix)
      `TMU_IX_MAIN: rd_val = r.main;
      `TMU_IX_RDREQ: rd_val = r.rdreq;
      `TMU_IX_BCLR, `TMU_IX_BSET: rd_val = {8'h00, r.ctlb};
      `TMU_IX_CAPC: rd_val = {8'h00, r.capc};
      `TMU_IX_DBG: rd_val = {8'h00, r.dbg};
      `TMU_IX_EVC: rd_val = r.evc;
      `TMU_IX_IECLR, `TMU_IX_IESET: rd_val = {8'h00, r.ien};
      `TMU_IX_FLAGS: rd_val = {8'h00, r.flags};
      `TMU_IX_STAT: rd_val = {8'h00, busy, 3'h0, r.stop, 3'h0};
      // Count is read from the snapshot taken on the counter side
      `TMU_IX_CNT: rd_val = {8'h00, r.cnt_rd[7:0]};
      `TMU_IX_CNTH: rd_val = {8'h00, r.cnt_rd[15:8]};
      `TMU_IX_PERIOD: rd_val = {8'h00, r.period};
      `TMU_IX_CMP0: rd_val = {8'h00, r.cmp0[7:0]};
      `TMU_IX_CMP0H: rd_val = {8'h00, m8 ? r.cmp1[7:0] : r.cmp0[15:8]};
      `TMU_IX_CMP1: rd_val = {8'h00, r.cmp1[7:0]};
      `TMU_IX_CMP1H: rd_val = {8'h00, r.cmp1[15:8]};
      default: rd_val = 16'h0000;
    endcase
  endfunction : rd_val

  // Applied only when the sync delay has run out
  function automatic tmu_regs_t apply_sync(input tmu_regs_t r, input logic [7:0] ix,
                                           input logic [7:0] d, input logic m8);
    tmu_regs_t o;
    o = r;
    case (ix)
      `TMU_IX_MAIN: begin
        if (d[`TMU_B_SOFT_RESET_BIT]) begin
          o = '0;
        end else begin
          o.main[`TMU_B_EN] = d[`TMU_B_EN];
        end
      end
      `TMU_IX_BCLR: o.ctlb = r.ctlb & ~d;
      `TMU_IX_BSET: o.ctlb = r.ctlb | d;
      `TMU_IX_CAPC: o.capc = d;
      `TMU_IX_CNT: o.cnt[7:0] = d;
      `TMU_IX_CNTH: o.cnt[15:8] = d;
      `TMU_IX_PERIOD: o.period = d;
      `TMU_IX_CMP0: o.cmp0[7:0] = d;
      `TMU_IX_CMP0H: begin
        if (m8) begin
          o.cmp1[7:0] = d;
        end else begin
          o.cmp0[15:8] = d;
        end
      end
      `TMU_IX_CMP1: o.cmp1[7:0] = d;
      `TMU_IX_CMP1H: o.cmp1[15:8] = d;
      default: o = r;
    endcase
    return o;
  endfunction : apply_sync

  logic busy;
  logic m8;
  logic evsig;
  logic ev_edge;
  logic retrig;
  logic step;
  logic wrap;
  logic [1:0] cmd;
  logic [2:0] evact;
  logic [15:0] top;
  logic [15:0] cmpv0;
  logic [15:0] cmpv1;
  logic [7:0] set_fl;
  logic [7:0] ix_w;

  always_comb begin
    nxt_s = s_ff;
    busy = s_ff.sync != st_idle;
    m8 = s_ff.r.main[`TMU_B_MODE +: 2] == `TMU_MODE_8;
    set_fl = 8'h00;
    nxt_s.ev_ovf = 1'b0;
    nxt_s.ev_mc0 = 1'b0;
    nxt_s.ev_mc1 = 1'b0;
    ix_w = s_ff.aw_ix;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_ix = {2'h0, s_axi_awaddr[7:2]};
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_d = s_axi_wdata[15:0];
      nxt_s.w_be = s_axi_wstrb[1:0];
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held = 1'b0;
    end
    // Writes wait while a sync runs, so one pending slot is enough
    if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid && !busy) begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = mapped(ix_w, m8) ? `TMU_RESP_OK : `TMU_RESP_ERR;
      if (mapped(ix_w, m8)) begin
        case (ix_w)
          `TMU_IX_MAIN: begin
            if (s_ff.w_be[0]) nxt_s.r.main[7:2] = s_ff.w_d[7:2];
            if (s_ff.w_be[1]) nxt_s.r.main[15:8] = s_ff.w_d[15:8];
          end
          `TMU_IX_RDREQ: begin
            if (s_ff.w_be[0]) nxt_s.r.rdreq[7:0] = s_ff.w_d[7:0];
            if (s_ff.w_be[1]) begin
              nxt_s.r.rdreq[15:8] = {1'b0, s_ff.w_d[14:8]};
              if (s_ff.w_d[`TMU_B_RREQ]) begin
                nxt_s.sync = st_rsync;
                nxt_s.sync_cnt = 4'(SYNC_CYC - 1);
              end
            end
          end
          `TMU_IX_DBG: if (s_ff.w_be[0]) nxt_s.r.dbg = s_ff.w_d[7:0];
          `TMU_IX_EVC: begin
            if (s_ff.w_be[0]) nxt_s.r.evc[7:0] = s_ff.w_d[7:0];
            if (s_ff.w_be[1]) nxt_s.r.evc[15:8] = s_ff.w_d[15:8];
          end
          `TMU_IX_IECLR: if (s_ff.w_be[0]) nxt_s.r.ien = s_ff.r.ien & ~s_ff.w_d[7:0];
          `TMU_IX_IESET: if (s_ff.w_be[0]) nxt_s.r.ien = s_ff.r.ien | s_ff.w_d[7:0];
          `TMU_IX_FLAGS: if (s_ff.w_be[0]) nxt_s.r.flags = s_ff.r.flags & ~s_ff.w_d[7:0];
          default: nxt_s.r = nxt_s.r;
        endcase
        if (is_sync(ix_w) && s_ff.w_be[0]) begin
          nxt_s.sync = st_wsync;
          nxt_s.sync_cnt = 4'(SYNC_CYC - 1);
          nxt_s.pend_ix = ix_w;
          nxt_s.pend_d = s_ff.w_d[7:0];
        end
      end
    end

    // Read channel
    if (s_axi_arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.ar_ix = {2'h0, s_axi_araddr[7:2]};
      // Refused reads must not leak the register behind an unmapped index
      if (mapped({2'h0, s_axi_araddr[7:2]}, m8)) begin
        nxt_s.rdata = {16'h0000, rd_val(s_ff.r, {2'h0, s_axi_araddr[7:2]}, m8, busy)};
      end else begin
        nxt_s.rdata = 32'h00000000;
      end
      nxt_s.rresp = mapped({2'h0, s_axi_araddr[7:2]}, m8) ? `TMU_RESP_OK : `TMU_RESP_ERR;
    end else if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end

    // Counter side; event actions do not depend on the standby gate
    evsig = ev_in ^ s_ff.r.evc[`TMU_B_EVINV];
    nxt_s.r.ev_d = evsig;
    ev_edge = evsig && !s_ff.r.ev_d && s_ff.r.evc[`TMU_B_EVIN_EN];
    evact = s_ff.r.evc[`TMU_B_EVACT +: 3];
    cmd = s_ff.r.ctlb[`TMU_B_CMD +: 2];
    nxt_s.r.ctlb[`TMU_B_CMD +: 2] = 2'h0;
    top = m8 ? {8'h00, s_ff.r.period} : 16'hffff;
    cmpv0 = m8 ? {8'h00, s_ff.r.cmp0[7:0]} : s_ff.r.cmp0;
    cmpv1 = m8 ? {8'h00, s_ff.r.cmp1[7:0]} : s_ff.r.cmp1;
    retrig = s_ff.r.main[`TMU_B_EN] &&
             (cmd == `TMU_CMD_RETRIG || (ev_edge && evact == `TMU_EVACT_RETRIG));
    step = s_ff.r.main[`TMU_B_EN] && !s_ff.r.stop &&
           (evact == `TMU_EVACT_COUNT ? ev_edge
            : (!standby || s_ff.r.main[`TMU_B_RUNSB]));
    wrap = s_ff.r.ctlb[`TMU_B_DIR] ? s_ff.r.cnt == 16'h0000 : s_ff.r.cnt == top;
    if (retrig) begin
      nxt_s.r.stop = 1'b0;
      nxt_s.r.cnt = s_ff.r.ctlb[`TMU_B_DIR] ? top : 16'h0000;
    end else if (s_ff.r.main[`TMU_B_EN] && cmd == `TMU_CMD_STOP) begin
      nxt_s.r.stop = 1'b1;
    end else if (step) begin
      if (wrap) begin
        nxt_s.r.cnt = s_ff.r.ctlb[`TMU_B_DIR] ? top : 16'h0000;
        set_fl[`TMU_F_OVF] = 1'b1;
        nxt_s.ev_ovf = s_ff.r.evc[`TMU_B_OVFEO];
        if (s_ff.r.ctlb[`TMU_B_SINGLE_SHOT_BIT]) nxt_s.r.stop = 1'b1;
      end else begin
        nxt_s.r.cnt = s_ff.r.ctlb[`TMU_B_DIR] ? s_ff.r.cnt - 16'h0001
                                              : s_ff.r.cnt + 16'h0001;
        // Narrow count stays in one byte; a period set below it rolls over at 0xff
        if (m8) nxt_s.r.cnt[15:8] = 8'h00;
      end
      if (s_ff.r.cnt == cmpv0) begin
        set_fl[`TMU_F_MC0] = 1'b1;
        nxt_s.ev_mc0 = s_ff.r.evc[`TMU_B_MCEO0];
      end
      if (s_ff.r.cnt == cmpv1) begin
        set_fl[`TMU_F_MC1] = 1'b1;
        nxt_s.ev_mc1 = s_ff.r.evc[`TMU_B_MCEO1];
      end
    end
    if (s_ff.r.rdreq[`TMU_B_RCONT]) nxt_s.r.cnt_rd = s_ff.r.cnt;

    // Sync delay stands in for the crossing into the counter clock
    if (busy) begin
      if (s_ff.sync_cnt == 4'h0) begin
        if (s_ff.sync == st_wsync) begin
          nxt_s.r = apply_sync(nxt_s.r, s_ff.pend_ix, s_ff.pend_d, m8);
        end else begin
          nxt_s.r.cnt_rd = s_ff.r.cnt;
        end
        nxt_s.sync = st_idle;
        set_fl[`TMU_F_SRDY] = 1'b1;
      end else begin
        nxt_s.sync_cnt = s_ff.sync_cnt - 4'h1;
      end
    end

    // Hardware set wins over a same-cycle software clear
    nxt_s.r.flags = nxt_s.r.flags | set_fl;
    nxt_s.irq = |(nxt_s.r.flags & nxt_s.r.ien);
    nxt_s.awready = !nxt_s.aw_held;
    nxt_s.wready = !nxt_s.w_held;
    nxt_s.arready = !nxt_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.sync <= st_idle;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign irq = s_ff.irq;
  assign ev_ovf = s_ff.ev_ovf;
  assign ev_mc0 = s_ff.ev_mc0;
  assign ev_mc1 = s_ff.ev_mc1;

  logic busy_q;
  assign busy_q = s_ff.sync != st_idle;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_wake_a: assert property ((s_ff.r.flags & s_ff.r.ien) != 8'h00 |-> irq)
    else $error("enabled flag set but irq low");
  busy_len_a: assert property ($rose(busy_q) |-> busy_q [*3] ##1 !busy_q)
    else $error("sync busy length wrong");
  sync_done_a: assert property ($fell(busy_q) |-> s_ff.r.flags[`TMU_F_SRDY])
    else $error("sync done flag not raised");
  en_delay_a: assert property ($rose(busy_q) |-> $stable(s_ff.r.main[`TMU_B_EN]) [*3])
    else $error("enable changed before sync end");
  stby_halt_a: assert property (standby && !s_ff.r.main[`TMU_B_RUNSB] && !busy_q &&
      !s_ff.r.evc[`TMU_B_EVIN_EN] |=> $stable(s_ff.r.cnt))
    else $error("counter moved in standby");
  stby_run_a: assert property (standby && s_ff.r.main[`TMU_B_RUNSB] &&
      s_ff.r.main[`TMU_B_EN] && !s_ff.r.stop && !s_ff.r.ctlb[`TMU_B_DIR] &&
      !s_ff.r.evc[`TMU_B_EVIN_EN] && s_ff.r.ctlb[7:6] == 2'h0 && !busy_q &&
      s_ff.r.cnt == 16'h0005 && !m8 |=> s_ff.r.cnt == 16'h0006)
    else $error("counter halted despite run in standby");
  one_shot_a: assert property (step && wrap && !retrig && s_ff.r.ctlb[`TMU_B_SINGLE_SHOT_BIT] &&
      s_ff.r.main[`TMU_B_EN] && s_ff.r.ctlb[7:6] == 2'h0 && !busy_q |=> s_ff.r.stop)
    else $error("single shot did not stop");
  snap_src_a: assert property ($changed(s_ff.r.cnt_rd) |->
      $past(s_ff.r.rdreq[`TMU_B_RCONT]) || $past(s_ff.sync == st_rsync) || $past(busy_q))
    else $error("count snapshot changed without sync");
  map8_a: assert property ($rose(s_axi_rvalid) && $past(m8) && s_ff.ar_ix == 8'h11 |->
      s_axi_rresp == `TMU_RESP_ERR)
    else $error("high count byte mapped in 8-bit width");
  map16_a: assert property ($rose(s_axi_rvalid) && !$past(m8) && s_ff.ar_ix == 8'h14 |->
      s_axi_rresp == `TMU_RESP_ERR)
    else $error("period mapped in 16-bit width");
  ovf_event_a: assert property (step && wrap && !retrig && s_ff.r.evc[`TMU_B_OVFEO] &&
      s_ff.r.main[`TMU_B_EN] && s_ff.r.ctlb[7:6] == 2'h0 |=> ev_ovf)
    else $error("overflow event missing");

  wsync_c: cover property ($fell(busy_q) && $past(s_ff.sync == st_wsync));
  rsync_c: cover property ($fell(busy_q) && $past(s_ff.sync == st_rsync));
  single_shot_bit_c: cover property ($rose(s_ff.r.stop));
  irq_c: cover property ($rose(irq) && standby);
endmodule : tmu_timer

// ==== src/placeholder_none.sv ====
// Intentionally empty compile unit
`timescale 1ns/1ps

// ==== test/tmu_evnet.sv ====
// Event network and sleep controller model facing the timer unit
`timescale 1ns/1ps
module tmu_evnet (
  // Clock
  input wire logic aclk,
  // Toward the timer
  output logic ev_in,
  output logic standby
);
  initial begin
    ev_in = 1'b0;
    standby = 1'b0;
  end

  // Level held two cycles so the rising edge is never lost
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge aclk);
      ev_in <= 1'b1;
      repeat (2) @(posedge aclk);
      ev_in <= 1'b0;
    end
  endtask : pulse

  task automatic sleep(input logic s);
    @(posedge aclk);
    standby <= s;
  endtask : sleep
endmodule : tmu_evnet

// ==== test/tmu_timer_bench.sv ====
// Register-level testbench of the timer unit
`timescale 1ns/1ps
`include "tmu_regs.svh"
module tmu_timer_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, standby, ev_in, irq;
  logic ev_ovf, ev_mc0, ev_mc1;
  int n_ovf = 0, n_mc0 = 0, n_mc1 = 0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, a, b;
  int error_cnt = 0;
  int total_checks = 0;
  logic [7:0] ixs [4] = '{`TMU_IX_CMP0, `TMU_IX_CMP0H, `TMU_IX_CMP1, `TMU_IX_CMP1H};
  logic [7:0] vals [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};

  always #12.5 aclk = ~aclk;

  // Event outputs are one-cycle pulses, so tally them on every edge
  always @(posedge aclk) begin
    if (ev_ovf === 1'b1) n_ovf <= n_ovf + 1;
    if (ev_mc0 === 1'b1) n_mc0 <= n_mc0 + 1;
    if (ev_mc1 === 1'b1) n_mc1 <= n_mc1 + 1;
  end

  tmu_evnet EVN (.aclk(aclk), .ev_in(ev_in), .standby(standby));

  tmu_timer DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .standby(standby), .ev_in(ev_in), .irq(irq),
    .ev_ovf(ev_ovf), .ev_mc0(ev_mc0), .ev_mc1(ev_mc1)
  );

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] ix, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {ix[5:0], 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check({32'h0, bresp}, {32'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] ix, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= {ix[5:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [7:0] ix, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(ix, d, r);
    check({r, d}, {er, exp});
  endtask : rd_chk

  task automatic sync_wait;
    logic [31:0] s;
    logic [1:0] r;
    for (int i = 0; i < 20; i++) begin
      rd(`TMU_IX_STAT, s, r);
      if (s[`TMU_S_BUSY] === 1'b0) break;
    end
    check({33'h0, s[`TMU_S_BUSY]}, 34'h0);
  endtask : sync_wait

  // Count reads return a snapshot, so refresh it first
  task automatic snap(output logic [31:0] c);
    logic [1:0] r;
    wr(`TMU_IX_RDREQ, 16'h8010, `TMU_RESP_OK);
    sync_wait;
    rd(`TMU_IX_CNT, c, r);
  endtask : snap

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`TMU_IX_MAIN, 32'h0, `TMU_RESP_OK);
    rd_chk(`TMU_IX_FLAGS, 32'h0, `TMU_RESP_OK);
    // Wide layout: both bytes of each channel, no period
    for (int i = 0; i < 4; i++) begin
      wr(ixs[i], {8'h00, vals[i]}, `TMU_RESP_OK);
      sync_wait;
      rd_chk(ixs[i], {24'h0, vals[i]}, `TMU_RESP_OK);
    end
    wr(`TMU_IX_PERIOD, 16'h0011, `TMU_RESP_ERR);
    rd_chk(`TMU_IX_PERIOD, 32'h0, `TMU_RESP_ERR);
    rd_chk(`TMU_IX_FLAGS, 32'h8, `TMU_RESP_OK);
    // Interrupt enable set, clear and flag clear
    wr(`TMU_IX_IESET, 16'h0008, `TMU_RESP_OK);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h1);
    wr(`TMU_IX_IECLR, 16'h0008, `TMU_RESP_OK);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    rd_chk(`TMU_IX_IESET, 32'h0, `TMU_RESP_OK);
    wr(`TMU_IX_IESET, 16'h0008, `TMU_RESP_OK);
    wr(`TMU_IX_FLAGS, 16'h0008, `TMU_RESP_OK);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    rd_chk(`TMU_IX_FLAGS, 32'h0, `TMU_RESP_OK);
    wr(`TMU_IX_IECLR, 16'h0008, `TMU_RESP_OK);
    // Single shot through set and clear views
    wr(`TMU_IX_BSET, 16'h0004, `TMU_RESP_OK);
    sync_wait;
    rd_chk(`TMU_IX_BCLR, 32'h4, `TMU_RESP_OK);
    wr(`TMU_IX_BCLR, 16'h0004, `TMU_RESP_OK);
    sync_wait;
    rd_chk(`TMU_IX_BSET, 32'h0, `TMU_RESP_OK);
    // Narrow layout
    wr(`TMU_IX_MAIN, 16'h0004, `TMU_RESP_OK);
    sync_wait;
    wr(`TMU_IX_PERIOD, 16'h0077, `TMU_RESP_OK);
    sync_wait;
    rd_chk(`TMU_IX_PERIOD, 32'h77, `TMU_RESP_OK);
    wr(`TMU_IX_CNTH, 16'h0001, `TMU_RESP_ERR);
    wr(`TMU_IX_CMP1, 16'h0001, `TMU_RESP_ERR);
    rd_chk(`TMU_IX_CNTH, 32'h0, `TMU_RESP_ERR);
    rd_chk(`TMU_IX_CMP0H, 32'h3c, `TMU_RESP_OK);
    rd_chk(`TMU_IX_CMP0, 32'h5a, `TMU_RESP_OK);
    wr(`TMU_IX_MAIN, 16'h0000, `TMU_RESP_OK);
    sync_wait;
    // Event counting keeps going while asleep
    wr(`TMU_IX_EVC, 16'h0022, `TMU_RESP_OK);
    wr(`TMU_IX_MAIN, 16'h0002, `TMU_RESP_OK);
    sync_wait;
    EVN.sleep(1'b1);
    EVN.pulse(3);
    snap(a);
    check({2'b00, a}, 34'h3);
    // Clock counting halts asleep unless told to keep running
    wr(`TMU_IX_EVC, 16'h0000, `TMU_RESP_OK);
    snap(a);
    repeat (20) @(posedge aclk);
    snap(b);
    check({33'h0, (a !== b)}, 34'h0);
    wr(`TMU_IX_MAIN, 16'h0802, `TMU_RESP_OK);
    sync_wait;
    snap(a);
    repeat (20) @(posedge aclk);
    snap(b);
    check({33'h0, (a !== b)}, 34'h1);
    // Overflow interrupt wakes from standby
    wr(`TMU_IX_IESET, 16'h0001, `TMU_RESP_OK);
    wr(`TMU_IX_EVC, 16'h3100, `TMU_RESP_OK);
    wr(`TMU_IX_MAIN, 16'h0806, `TMU_RESP_OK);
    sync_wait;
    // Matches inside the short period so both channels fire
    wr(`TMU_IX_CMP0, 16'h0005, `TMU_RESP_OK);
    sync_wait;
    wr(`TMU_IX_CMP0H, 16'h0008, `TMU_RESP_OK);
    sync_wait;
    wr(`TMU_IX_PERIOD, 16'h0010, `TMU_RESP_OK);
    sync_wait;
    repeat (300) @(posedge aclk);
    check({33'h0, irq}, 34'h1);
    rd_chk(`TMU_IX_FLAGS, 32'h39, `TMU_RESP_OK);
    check({33'h0, (n_ovf > 0)}, 34'h1);
    check({33'h0, (n_mc0 > 0)}, 34'h1);
    check({33'h0, (n_mc1 > 0)}, 34'h1);
    // Single shot stops at the next wrap; commands restart and halt it
    wr(`TMU_IX_BSET, 16'h0004, `TMU_RESP_OK);
    sync_wait;
    repeat (40) @(posedge aclk);
    rd_chk(`TMU_IX_STAT, 32'h8, `TMU_RESP_OK);
    wr(`TMU_IX_BCLR, 16'h0004, `TMU_RESP_OK);
    sync_wait;
    wr(`TMU_IX_BSET, 16'h0040, `TMU_RESP_OK);
    sync_wait;
    rd_chk(`TMU_IX_STAT, 32'h0, `TMU_RESP_OK);
    wr(`TMU_IX_BSET, 16'h0080, `TMU_RESP_OK);
    sync_wait;
    rd_chk(`TMU_IX_STAT, 32'h8, `TMU_RESP_OK);
    // Soft reset clears every register except the sync-ready flag after the sync delay
    wr(`TMU_IX_MAIN, 16'h0001, `TMU_RESP_OK);
    sync_wait;
    rd_chk(`TMU_IX_MAIN, 32'h0, `TMU_RESP_OK);
    rd_chk(`TMU_IX_IESET, 32'h0, `TMU_RESP_OK);
    rd_chk(`TMU_IX_STAT, 32'h0, `TMU_RESP_OK);
    check({33'h0, irq}, 34'h0);
    EVN.sleep(1'b0);
    report_and_stop;
  end
endmodule : tmu_timer_bench
